/* shared/serial_pin_pkg.sv */
// Constants, field layout and carrier types for the shared serial port pin control
//--------------------------------------------------------------------------------
// Behaviour
// - Three-bit SPI interrupt level; zero disables requests, seven is highest.
// - On equal level and simultaneous request, the SPI is granted before serial.
// - Assignment bit set gives pin to SPI, cleared gives it to general I/O.
// - No assignment bits at positions seven to four or two.
// - Clock pin belongs to SPI whenever SPI enable is set, else general I/O.
// - General I/O SPI pins follow only direction and data registers.
// - Pin assignment never changes either serial interface's pins.
// - One direction bit per pin; all pins are inputs during reset.
// - Master-in pin: master 0 input, 1 disabled; slave 0 disabled, 1 output.
// - Master-out pin: master 0 disabled, 1 output; slave 0 input, 1 disabled.
// - SPI clock pin is output as master, input as slave, ignoring direction.
// - Select pin: master 0 fault on assert, 1 general I/O; slave 0 on, 1 off.
// - Direction bits four to seven pick general I/O at 0, serial at 1.
// - Serial receive pin falls back to general I/O while receiver disabled.
// - Serial transmit pin falls back to general I/O while transmitter disabled.
// - Data writes go to a latch driven onto every discrete output pin.
// - Data read returns pin level for discrete inputs, latch otherwise.
// - Pin-state read returns actual pin levels; writes to it are ignored.
// - Data latch value is undefined after reset; upper bits read zero.
//--------------------------------------------------------------------------------
package serial_pin_pkg;

    //--------------------------------------------------------------------
    // Register map (byte addresses on the APB)
    //--------------------------------------------------------------------
    localparam int          ADDR_WIDTH       = 8;
    localparam logic [7:0]  OFF_IRQ_LEVEL    = 8'h00;
    localparam logic [7:0]  OFF_PIN_ASSIGN   = 8'h04;
    localparam logic [7:0]  OFF_DIRECTION    = 8'h08;
    localparam logic [7:0]  OFF_DATA_LATCH   = 8'h0C;
    localparam logic [7:0]  OFF_PIN_STATE    = 8'h10;

    //--------------------------------------------------------------------
    // Field layout and reset values
    //--------------------------------------------------------------------
    localparam logic [7:0]  ASSIGN_MASK      = 8'h0B;
    localparam int          PIN_MISO         = 0;
    localparam int          PIN_MOSI         = 1;
    localparam int          PIN_SCK          = 2;
    localparam int          PIN_SS           = 3;
    localparam int          PIN_SCI_B_RX     = 4;
    localparam int          PIN_SCI_B_TX     = 5;
    localparam int          PIN_SCI_A_RX     = 6;
    localparam int          PIN_SCI_A_TX     = 7;
    localparam logic [2:0]  IRQ_LEVEL_RESET  = 3'h0;
    localparam logic [7:0]  DIRECTION_RESET  = 8'h00;
    localparam logic [7:0]  LATCH_RESET      = 8'h00;

    //--------------------------------------------------------------------
    // Interrupt source codes
    //--------------------------------------------------------------------
    localparam logic [1:0]  SRC_SCI_A        = 2'h0;
    localparam logic [1:0]  SRC_SCI_B        = 2'h1;
    localparam logic [1:0]  SRC_SPI          = 2'h2;

    //--------------------------------------------------------------------
    // Carrier types
    //--------------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic       master;
        logic       mosi_out;
        logic       miso_out;
        logic       sck_out;
    } spi_drive_type;

    typedef struct packed {
        logic       miso_in;
        logic       mosi_in;
        logic       sck_in;
        logic       select_in_n;
        logic       mode_fault;
    } spi_sense_type;

    typedef struct packed {
        logic       receiver_enable_bit;
        logic       transmitter_enable_bit;
        logic       tx_data;
    } sci_drive_type;

    typedef struct packed {
        logic       req;
        logic [2:0] level;
    } irq_req_type;

    typedef struct packed {
        logic       valid;
        logic [2:0] level;
        logic [1:0] source;
    } irq_grant_type;

    typedef struct packed {
        logic [2:0]    spi_irq_level;
        logic [7:0]    spi_pin_assignment;
        logic [7:0]    port_direction;
        logic [7:0]    port_data_latch;
        logic [7:0]    sync1;
        logic [7:0]    sync2;
        logic [31:0]   prdata;
        logic          pslverr;
        logic [7:0]    pin_out;
        logic [7:0]    pin_oe;
        spi_sense_type spi_sense;
        logic          sci_a_rx;
        logic          sci_b_rx;
        irq_grant_type grant;
    } state_type;

    localparam state_type STATE_RESET = '{
        spi_irq_level:      IRQ_LEVEL_RESET,
        spi_pin_assignment: 8'h00,
        port_direction:     DIRECTION_RESET,
        port_data_latch:    LATCH_RESET,
        sync1:              8'h00,
        sync2:              8'h00,
        prdata:             32'h0000_0000,
        pslverr:            1'b0,
        pin_out:            8'h00,
        pin_oe:             8'h00,
        spi_sense:          5'b1_1110,
        sci_a_rx:           1'b1,
        sci_b_rx:           1'b1,
        grant:              6'h00
    };

endpackage

/* verilog/serial_port_pin_control.sv */
// Pin ownership, direction, general I/O port and SPI interrupt ranking with APB access
`timescale 1ns/1ps

module serial_port_pin_control
    import serial_pin_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Port pins
    input  wire logic [7:0]            pin_in,
    output logic [7:0]                 pin_out,
    output logic [7:0]                 pin_oe,
    // SPI side
    input  wire spi_drive_type         spi_drive,
    output spi_sense_type              spi_sense,
    // Serial interfaces
    input  wire sci_drive_type         serial_if_a,
    input  wire sci_drive_type         serial_if_b,
    output logic                       serial_a_rx_pin,
    output logic                       serial_b_rx_pin,
    // Interrupt ranking
    input  wire logic                  spi_irq_req,
    input  wire irq_req_type           sci_a_irq,
    input  wire irq_req_type           sci_b_irq,
    output irq_grant_type              irq_grant
);

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    state_type r;
    state_type next_r;

    // Effective level of a request, zero when not requesting or disabled
    function automatic logic [2:0] eff_level(input logic req, input logic [2:0] lvl);
        return req ? lvl : 3'h0;
    endfunction

    // Pin owned by general I/O: direction bit picks driver, latch gives level
    function automatic logic [1:0] gpio_drive(input logic dir, input logic latch);
        return {dir, latch};
    endfunction

    logic       setup_phase;
    logic       access_phase;
    logic [2:0] lvl_spi;
    logic [2:0] lvl_a;
    logic [2:0] lvl_b;
    logic [7:0] gpio_owned;
    logic [7:0] read_back;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign lvl_spi      = eff_level(spi_irq_req, r.spi_irq_level);
    assign lvl_a        = eff_level(sci_a_irq.req, sci_a_irq.level);
    assign lvl_b        = eff_level(sci_b_irq.req, sci_b_irq.level);

    //--------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------
    // Pin decisions read the control registers and the live SPI and serial drive inputs, and are registered, so pins change one
    // cycle after a write; the extra cycle keeps pin outputs glitch free.
    always_comb
    begin
        next_r = r;
        gpio_owned = 8'h00;

        // Two-stage synchroniser for the asynchronous pin levels
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;

        // Register writes take effect at the access edge
        if (access_phase && pwrite && pstrb[0])
        begin
            case (paddr)
                OFF_IRQ_LEVEL:  next_r.spi_irq_level = pwdata[2:0];
                // Absent assignment bits are masked here so they always read zero
                OFF_PIN_ASSIGN: next_r.spi_pin_assignment = pwdata[7:0] & ASSIGN_MASK;
                OFF_DIRECTION:  next_r.port_direction = pwdata[7:0];
                OFF_DATA_LATCH: next_r.port_data_latch = pwdata[7:0];
                default:        next_r.port_data_latch = r.port_data_latch;
            endcase
        end

        // Default drive and sense values: SPI and serial inputs idle high
        next_r.spi_sense = STATE_RESET.spi_sense;
        next_r.sci_a_rx  = 1'b1;
        next_r.sci_b_rx  = 1'b1;

        // Master-in pin
        if (r.spi_pin_assignment[PIN_MISO])
        begin
            if (spi_drive.master)
            begin
                {next_r.pin_oe[PIN_MISO], next_r.pin_out[PIN_MISO]} = 2'b00;
                next_r.spi_sense.miso_in = r.port_direction[PIN_MISO] ? 1'b1
                                                                      : r.sync2[PIN_MISO];
            end
            else
            begin
                next_r.pin_oe[PIN_MISO]  = r.port_direction[PIN_MISO];
                next_r.pin_out[PIN_MISO] = r.port_direction[PIN_MISO] && spi_drive.miso_out;
            end
        end
        else
        begin
            gpio_owned[PIN_MISO] = 1'b1;
        end

        // Master-out pin
        if (r.spi_pin_assignment[PIN_MOSI])
        begin
            if (spi_drive.master)
            begin
                next_r.pin_oe[PIN_MOSI]  = r.port_direction[PIN_MOSI];
                next_r.pin_out[PIN_MOSI] = r.port_direction[PIN_MOSI] && spi_drive.mosi_out;
            end
            else
            begin
                {next_r.pin_oe[PIN_MOSI], next_r.pin_out[PIN_MOSI]} = 2'b00;
                next_r.spi_sense.mosi_in = r.port_direction[PIN_MOSI] ? 1'b1
                                                                      : r.sync2[PIN_MOSI];
            end
        end
        else
        begin
            gpio_owned[PIN_MOSI] = 1'b1;
        end

        // Clock pin follows the SPI enable alone, never an assignment bit
        if (spi_drive.enable)
        begin
            if (spi_drive.master)
            begin
                next_r.pin_oe[PIN_SCK]  = 1'b1;
                next_r.pin_out[PIN_SCK] = spi_drive.sck_out;
            end
            else
            begin
                {next_r.pin_oe[PIN_SCK], next_r.pin_out[PIN_SCK]} = 2'b00;
                next_r.spi_sense.sck_in = r.sync2[PIN_SCK];
            end
        end
        else
        begin
            gpio_owned[PIN_SCK] = 1'b1;
        end

        // Slave-select pin; select is active low on the wire
        if (r.spi_pin_assignment[PIN_SS] && !(spi_drive.master && r.port_direction[PIN_SS]))
        begin
            {next_r.pin_oe[PIN_SS], next_r.pin_out[PIN_SS]} = 2'b00;
            if (spi_drive.master)
                next_r.spi_sense.mode_fault = spi_drive.enable && !r.sync2[PIN_SS];
            else
                next_r.spi_sense.select_in_n = r.port_direction[PIN_SS]
                                               | r.sync2[PIN_SS];
        end
        else
        begin
            gpio_owned[PIN_SS] = 1'b1;
        end

        // Serial pins ignore the assignment register entirely
        if (r.port_direction[PIN_SCI_B_RX] && serial_if_b.receiver_enable_bit)
        begin
            {next_r.pin_oe[PIN_SCI_B_RX], next_r.pin_out[PIN_SCI_B_RX]} = 2'b00;
            next_r.sci_b_rx = r.sync2[PIN_SCI_B_RX];
        end
        else
        begin
            gpio_owned[PIN_SCI_B_RX] = 1'b1;
        end
        if (r.port_direction[PIN_SCI_A_RX] && serial_if_a.receiver_enable_bit)
        begin
            {next_r.pin_oe[PIN_SCI_A_RX], next_r.pin_out[PIN_SCI_A_RX]} = 2'b00;
            next_r.sci_a_rx = r.sync2[PIN_SCI_A_RX];
        end
        else
        begin
            gpio_owned[PIN_SCI_A_RX] = 1'b1;
        end
        if (r.port_direction[PIN_SCI_B_TX] && serial_if_b.transmitter_enable_bit)
            {next_r.pin_oe[PIN_SCI_B_TX], next_r.pin_out[PIN_SCI_B_TX]} =
                {1'b1, serial_if_b.tx_data};
        else
            gpio_owned[PIN_SCI_B_TX] = 1'b1;
        if (r.port_direction[PIN_SCI_A_TX] && serial_if_a.transmitter_enable_bit)
            {next_r.pin_oe[PIN_SCI_A_TX], next_r.pin_out[PIN_SCI_A_TX]} =
                {1'b1, serial_if_a.tx_data};
        else
            gpio_owned[PIN_SCI_A_TX] = 1'b1;

        // General I/O pins: only direction and latch, no peripheral influence
        for (int i = 0; i < 8; i++)
        begin
            if (gpio_owned[i])
                {next_r.pin_oe[i], next_r.pin_out[i]} = gpio_drive(r.port_direction[i],
                                                                 r.port_data_latch[i]);
        end

        // Read data is captured in the setup cycle and shown in the access cycle
        if (setup_phase)
        begin
            next_r.pslverr = 1'b0;
            case (paddr)
                OFF_IRQ_LEVEL:  next_r.prdata = {29'h0, r.spi_irq_level};
                OFF_PIN_ASSIGN: next_r.prdata = {24'h00_0000, r.spi_pin_assignment};
                OFF_DIRECTION:  next_r.prdata = {24'h00_0000, r.port_direction};
                OFF_DATA_LATCH: next_r.prdata = {24'h00_0000, read_back};
                OFF_PIN_STATE:  next_r.prdata = {24'h00_0000, r.sync2};
                default:
                begin
                    next_r.prdata  = 32'h0000_0000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end

        // Interrupt ranking: highest level wins, SPI wins a tie, then A over B
        next_r.grant.valid  = (lvl_spi != 3'h0) || (lvl_a != 3'h0) || (lvl_b != 3'h0);
        if (lvl_spi != 3'h0 && lvl_spi >= lvl_a && lvl_spi >= lvl_b)
        begin
            next_r.grant.level  = lvl_spi;
            next_r.grant.source = SRC_SPI;
        end
        else if (lvl_a >= lvl_b)
        begin
            next_r.grant.level  = lvl_a;
            next_r.grant.source = SRC_SCI_A;
        end
        else
        begin
            next_r.grant.level  = lvl_b;
            next_r.grant.source = SRC_SCI_B;
        end
        if (!next_r.grant.valid)
            next_r.grant = '0;
    end

    // Discrete input pins read the pin, everything else reads the latch
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            read_back[i] = (gpio_owned[i] && !r.port_direction[i]) ? r.sync2[i]
                                                                  : r.port_data_latch[i];
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    // Reset makes every pin an input; the latch gets a fixed value though its
    // content is not promised to software.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= STATE_RESET;
        else
            r <= next_r;
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    assign pready          = 1'b1;
    assign prdata          = r.prdata;
    assign pslverr         = r.pslverr && access_phase;
    assign pin_out         = r.pin_out;
    assign pin_oe          = r.pin_oe;
    assign spi_sense       = r.spi_sense;
    assign serial_a_rx_pin = r.sci_a_rx;
    assign serial_b_rx_pin = r.sci_b_rx;
    assign irq_grant       = r.grant;

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_irq_zero_disables: assert property ((r.spi_irq_level == 3'h0) ##1 (r.spi_irq_level == 3'h0)
        |-> irq_grant.source != SRC_SPI || !irq_grant.valid)
        else $error("SPI granted with level zero");
    a_spi_tie_wins: assert property ((lvl_spi != 3'h0 && lvl_spi == lvl_a && lvl_a >= lvl_b)
        |=> irq_grant.valid && irq_grant.source == SRC_SPI
            && irq_grant.level == $past(lvl_spi))
        else $error("SPI lost an equal-level tie");
    a_assign_unused_zero: assert property (r.spi_pin_assignment[7:4] == 4'h0
        && !r.spi_pin_assignment[2])
        else $error("Unimplemented assignment bit set");
    a_gpio_master_in: assert property ((!r.spi_pin_assignment[PIN_MISO]
        && r.port_direction[PIN_MISO])
        |=> pin_oe[PIN_MISO] && pin_out[PIN_MISO] == $past(r.port_data_latch[PIN_MISO]))
        else $error("General output pin not driven from latch");
    a_sck_master_out: assert property ((spi_drive.enable && spi_drive.master)
        |=> pin_oe[PIN_SCK] && pin_out[PIN_SCK] == $past(spi_drive.sck_out))
        else $error("Clock pin not driven in master mode");
    a_sck_slave_in: assert property ((spi_drive.enable && !spi_drive.master)
        |=> !pin_oe[PIN_SCK])
        else $error("Clock pin driven in slave mode");
    a_slave_miso_out: assert property ((r.spi_pin_assignment[PIN_MISO] && !spi_drive.master)
        |=> pin_oe[PIN_MISO] == $past(r.port_direction[PIN_MISO]))
        else $error("Master-in pin direction wrong in slave mode");
    a_master_mosi_out: assert property ((r.spi_pin_assignment[PIN_MOSI] && spi_drive.master)
        |=> pin_oe[PIN_MOSI] == $past(r.port_direction[PIN_MOSI]))
        else $error("Master-out pin direction wrong in master mode");
    a_mode_fault_raise: assert property ((r.spi_pin_assignment[PIN_SS] && spi_drive.master
        && spi_drive.enable && !r.port_direction[PIN_SS] && !r.sync2[PIN_SS])
        |=> spi_sense.mode_fault)
        else $error("Mode fault missed");
    a_sci_tx_drive: assert property ((r.port_direction[PIN_SCI_A_TX]
        && serial_if_a.transmitter_enable_bit)
        |=> pin_oe[PIN_SCI_A_TX] && pin_out[PIN_SCI_A_TX] == $past(serial_if_a.tx_data))
        else $error("Serial transmit pin not driven");
    a_sci_rx_fallback: assert property ((r.port_direction[PIN_SCI_B_RX]
        && !serial_if_b.receiver_enable_bit)
        |=> pin_oe[PIN_SCI_B_RX]
            && pin_out[PIN_SCI_B_RX] == $past(r.port_data_latch[PIN_SCI_B_RX]))
        else $error("Receive pin did not fall back to general I/O");
    a_pin_state_read: assert property ((setup_phase && !pwrite && paddr == OFF_PIN_STATE)
        |=> prdata == {24'h00_0000, $past(r.sync2)})
        else $error("Pin-state read wrong");
    a_pin_state_nowrite: assert property ((access_phase && pwrite && paddr == OFF_PIN_STATE)
        |=> $stable(r.port_direction) && $stable(r.port_data_latch))
        else $error("Pin-state write changed state");
    a_latch_write: assert property ((access_phase && pwrite && pstrb[0] && paddr == OFF_DATA_LATCH)
        |=> r.port_data_latch == $past(pwdata[7:0]))
        else $error("Latch write lost");

    // Slave sense paths, serial receive routing, clock pin as general I/O, ranking and read padding
    a_mosi_slave_in: assert property (
        (r.spi_pin_assignment[PIN_MOSI] && !spi_drive.master && !r.port_direction[PIN_MOSI])
        |=> spi_sense.mosi_in == $past(r.sync2[PIN_MOSI]))
        else $error("Master-out pin not sensed in slave mode");
    a_select_slave: assert property (
        (r.spi_pin_assignment[PIN_SS] && !spi_drive.master)
        |=> spi_sense.select_in_n == ($past(r.port_direction[PIN_SS]) | $past(r.sync2[PIN_SS])))
        else $error("Slave select not sensed");
    a_rx_b_follow: assert property (
        (r.port_direction[PIN_SCI_B_RX] && serial_if_b.receiver_enable_bit)
        |=> !pin_oe[PIN_SCI_B_RX] && serial_b_rx_pin == $past(r.sync2[PIN_SCI_B_RX]))
        else $error("Serial receive pin not routed");
    a_sck_gpio: assert property (
        !spi_drive.enable |=> pin_oe[PIN_SCK] == $past(r.port_direction[PIN_SCK]))
        else $error("Clock pin not general I/O while SPI disabled");
    a_grant_level: assert property (
        (sci_a_irq.req && sci_a_irq.level != 3'h0)
        |=> irq_grant.valid && irq_grant.level >= $past(sci_a_irq.level))
        else $error("Grant below a pending request level");
    a_read_upper_zero: assert property (
        (setup_phase && paddr == OFF_DIRECTION) |=> prdata[31:8] == 24'h00_0000)
        else $error("Upper read bits not zero");

    c_spi_master: cover property (spi_drive.enable && spi_drive.master ##1 pin_oe[PIN_SCK]);
    c_spi_tie: cover property (lvl_spi != 3'h0 && lvl_spi == lvl_a ##1 irq_grant.valid);
    c_sci_tx: cover property (pin_oe[PIN_SCI_A_TX] && serial_if_a.transmitter_enable_bit);
    c_gpio_read: cover property (setup_phase && paddr == OFF_DATA_LATCH
        && r.port_direction == 8'h00);
    c_mode_fault: cover property (spi_sense.mode_fault);

endmodule

/* tb/pin_partner.sv */
// Model of the port pins as seen from outside the device
`timescale 1ns/1ps
module pin_partner
(
    // Device drive and outside level
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_level,
    // Level back into the device
    output logic [7:0]      pin_in
);
    // Driven pins show the device level; released pins follow the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* tb/serial_port_pin_control_bench.sv */
// Self-checking bench for the serial port pin control block
`timescale 1ns/1ps
module serial_port_pin_control_bench;
    import serial_pin_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, a_rx, b_rx, spi_irq_req;
    logic [7:0] paddr, pin_in, pin_out, pin_oe, ext_level;
    logic [31:0] pwdata, prdata, d;
    spi_drive_type spi_drive;
    spi_sense_type spi_sense;
    sci_drive_type sci_a, sci_b;
    irq_req_type sci_a_irq, sci_b_irq;
    irq_grant_type irq_grant;
    int fail_count = 0;
    int checks_done = 0;

    serial_port_pin_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .spi_drive(spi_drive), .spi_sense(spi_sense),
        .serial_if_a(sci_a), .serial_if_b(sci_b), .serial_a_rx_pin(a_rx),
        .serial_b_rx_pin(b_rx), .spi_irq_req(spi_irq_req), .sci_a_irq(sci_a_irq),
        .sci_b_irq(sci_b_irq), .irq_grant(irq_grant));
    pin_partner u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));

    // Clock at 40 MHz
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    //----------------------------------------------------------------
    // Tasks
    //----------------------------------------------------------------
    // One APB transfer; an idle edge follows so psel is never set twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            // No cycle limit here: only the watchdog ends a hung wait
            do
                @(posedge pclk);
            while (pready !== 1'b1);
            d = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, d);
    endtask

    task automatic results;
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog sized well above the short test sequence
    initial
    begin
        #(3000 * 25);
        fail_count++;
        results();
    end

    //----------------------------------------------------------------
    // Tests
    //----------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, spi_irq_req} = '0;
        {spi_drive, sci_a, sci_b, sci_a_irq, sci_b_irq} = '0;
        ext_level = 8'h3C;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("pin_oe", 32'h0000_0000, {24'h0, pin_oe});
        rchk("direction", OFF_DIRECTION, 32'h0000_0000);
        apb(1'b1, OFF_PIN_ASSIGN, 32'hFFFF_FFFF);
        rchk("assignment", OFF_PIN_ASSIGN, {24'h0, ASSIGN_MASK});
        $display("Test reset done");
        // Assign to I/O, write the byte, then turn the pins to outputs
        apb(1'b1, OFF_PIN_ASSIGN, 32'h0000_0000);
        apb(1'b1, OFF_DATA_LATCH, 32'h0000_00A5);
        apb(1'b1, OFF_DIRECTION, 32'h0000_00FF);
        repeat (2) @(posedge pclk);
        check("pin_oe", 32'h0000_00FF, {24'h0, pin_oe});
        check("pin_out", 32'h0000_00A5, {24'h0, pin_out});
        $display("Test output port done");
        // Master-in to SPI as master, clock pin owned by enabled SPI
        spi_drive <= '{enable: 1'b1, master: 1'b1, default: 1'b0};
        apb(1'b1, OFF_DIRECTION, 32'h0000_0000);
        apb(1'b1, OFF_PIN_ASSIGN, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        check("pin_oe", 32'h0000_0004, {24'h0, pin_oe});
        check("miso_in", 32'h0000_0000, {31'h0, spi_sense.miso_in});
        rchk("data", OFF_DATA_LATCH, 32'h0000_003D);
        apb(1'b1, OFF_PIN_STATE, 32'h0000_00FF);
        rchk("pin_state", OFF_PIN_STATE, 32'h0000_0038);
        $display("Test SPI pins done");
        // Serial pins ignore the assignment bits
        spi_drive <= '0;
        sci_a <= '{receiver_enable_bit: 1'b0, transmitter_enable_bit: 1'b1, tx_data: 1'b0};
        sci_b <= '{receiver_enable_bit: 1'b1, default: 1'b0};
        ext_level <= 8'h2C;
        apb(1'b1, OFF_PIN_ASSIGN, 32'h0000_000B);
        apb(1'b1, OFF_DIRECTION, 32'h0000_0090);
        repeat (3) @(posedge pclk);
        check("tx pin", 32'h0000_0002, {30'h0, pin_oe[7], pin_out[7]});
        check("rx pin", 32'h0000_0000, {31'h0, b_rx});
        $display("Test serial pins done");
        // Master with select pin low raises a mode fault; then slave mode
        spi_drive <= '{enable: 1'b1, master: 1'b1, mosi_out: 1'b1, default: 1'b0};
        sci_b <= '0;
        ext_level <= 8'h24;
        apb(1'b1, OFF_DIRECTION, 32'h0000_0012);
        repeat (4) @(posedge pclk);
        check("pin_oe", 32'h0000_0016, {24'h0, pin_oe});
        check("driven", 32'h0000_0002, {24'h0, pin_oe & pin_out});
        check("mode_fault", 32'h0000_0001, {31'h0, spi_sense.mode_fault});
        check("rx pin", 32'h0000_0001, {31'h0, b_rx});
        spi_drive <= '{enable: 1'b1, default: 1'b0};
        repeat (4) @(posedge pclk);
        check("pin_oe", 32'h0000_0010, {24'h0, pin_oe});
        check("select_in_n", 32'h0000_0000, {31'h0, spi_sense.select_in_n});
        $display("Test SPI modes done");
        // Equal levels: SPI first; level zero leaves SPI out
        apb(1'b1, OFF_IRQ_LEVEL, 32'h0000_0005);
        spi_irq_req <= 1'b1;
        sci_a_irq <= '{req: 1'b1, level: 3'h5};
        repeat (2) @(posedge pclk);
        check("grant", {26'h0, 1'b1, 3'h5, SRC_SPI}, {26'h0, irq_grant});
        apb(1'b1, OFF_IRQ_LEVEL, 32'h0000_0000);
        @(posedge pclk);
        check("grant", {26'h0, 1'b1, 3'h5, SRC_SCI_A}, {26'h0, irq_grant});
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("pslverr", 32'h0000_0001, {31'h0, err});
        $display("Test interrupt and map done");
        results();
    end
endmodule
